// ### dbg_port_cmd.v
// Command layer of a single-wire debug port: instruction decode, repeat,
// keys, info block readout, control space and chip-erase handshake.
// Assumes a byte-level PHY (synch, break, rx/tx bytes) on the same clock.
`timescale 1ns/10ps
`include "dbg_port_consts.vh"

module dbg_port_cmd #(
  // Arbitrary info block contents, byte 0 in the low bits
  parameter [127:0] INFO_BLOCK = 128'h00_3a_00_00_00_00_00_00_20_20_00_00_00_00_00_00
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Link receive side
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_synch,
  input wire rx_break,
  // Link transmit side
  output reg tx_valid,
  output reg [7:0] tx_data,
  output reg [7:0] tx_idle,
  input wire tx_ready,
  // System bus master
  output reg bus_req,
  output reg bus_we,
  output reg [15:0] bus_addr,
  output reg [7:0] bus_wdata,
  input wire bus_ack,
  input wire [7:0] bus_rdata,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // System control
  input wire lock_in,
  input wire prog_done,
  input wire urow_done,
  input wire port_disable,
  input wire erase_done,
  input wire [2:0] bod_cfg_level,
  output reg sys_reset,
  output reg erase_start,
  output reg bod_force,
  output reg [1:0] bod_active,
  output reg [2:0] bod_level,
  output reg nvm_prog_en,
  output reg urow_prog_en
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_INSTR = 4'h1;
  localparam [3:0] S_START = 4'h2;
  localparam [3:0] S_ADDR = 4'h3;
  localparam [3:0] S_DATA = 4'h4;
  localparam [3:0] S_BUS = 4'h5;
  localparam [3:0] S_TX = 4'h6;
  localparam [3:0] S_KEY = 4'h7;
  localparam [3:0] S_CSDATA = 4'h8;
  localparam [3:0] S_RPT = 4'h9;

  localparam [1:0] SRC_DATA = 2'h0;
  localparam [1:0] SRC_INFO = 2'h1;
  localparam [1:0] SRC_BYTE = 2'h2;

  reg [3:0] state_r;
  reg [7:0] op_r;
  reg [7:0] rpt_r;
  reg [4:0] cnt_r;
  reg [4:0] idx_r;
  reg [15:0] addr_r;
  reg [15:0] ptr_r;
  reg [15:0] data_r;
  reg [63:0] key_sr_r;
  reg [1:0] src_r;
  reg [7:0] byte_r;
  reg first_r;
  reg [7:0] ctrla_r;
  reg [7:0] reset_req_r;
  reg erase_key_r;
  reg prog_key_r;
  reg urow_key_r;
  reg lock_r;

  wire [2:0] op_class = op_r[`OPF_CLASS_HI:`OPF_CLASS_LO];
  wire [1:0] ptr_mode = op_r[`OPF_PTR_HI:`OPF_PTR_LO];
  wire [4:0] dbytes = op_r[`OPF_DSIZE] ? 5'h02 : 5'h01;
  wire [4:0] abytes = op_r[`OPF_ASIZE] ? 5'h02 : 5'h01;
  wire last_idx = (idx_r + 5'h01 == cnt_r);
  wire [63:0] key_next = {rx_data, key_sr_r[63:8]};

  // Control-space read view, shared by the link and the register port
  function [7:0] cs_read;
    input [3:0] a;
    begin
      cs_read = 8'h00;
      case (a)
        `CS_CTRLA: cs_read = ctrla_r;
        `CS_KEY_STATUS: begin
          cs_read[`KS_ERASE] = erase_key_r;
          cs_read[`KS_PROG] = prog_key_r;
          cs_read[`KS_UROW] = urow_key_r;
        end
        `CS_RESET_REQ: cs_read = reset_req_r;
        `CS_SYS_STATUS: begin
          cs_read[`SS_LOCK] = lock_r;
          cs_read[`SS_USER_ROW_PROGRAMMING_FLAG] = urow_prog_en;
          cs_read[`SS_MEMORY_PROGRAMMING_KEY] = nvm_prog_en;
          cs_read[`SS_RSTSYS] = sys_reset;
        end
        default: cs_read = 8'h00;
      endcase
    end
  endfunction

  // Idle bits before the first byte after turnaround
  function [7:0] guard_bits;
    input [2:0] g;
    begin
      if (g == `GT_NONE)
        guard_bits = 8'h00;
      else
        guard_bits = `GT_MAX_BITS >> g;
    end
  endfunction

  // Control-space writer: link store wins over a colliding port write
  wire link_cs_we = (state_r == S_CSDATA) && rx_valid && !rx_break;
  wire cs_we = link_cs_we || reg_wr;
  wire [3:0] cs_wa = link_cs_we ? op_r[3:0] : reg_addr;
  wire [7:0] cs_wd = link_cs_we ? rx_data : reg_wdata;
  wire rst_release = cs_we && (cs_wa == `CS_RESET_REQ) &&
    (cs_wd == `RESET_RELEASE) && sys_reset;
  wire key_done = (state_r == S_KEY) && rx_valid && !rx_break && last_idx;
  wire urow_clr = cs_we && (cs_wa == `CS_KEY_STATUS) && cs_wd[`KS_UROW];

  always @(posedge clk) begin
    if (rst) begin
      ctrla_r <= `CTRLA_RESET;
      reset_req_r <= `RESET_REQ_RESET;
      sys_reset <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_rd)
        reg_rdata <= cs_read(reg_addr);
      else
        reg_rdata <= 8'h00;
      if (cs_we && cs_wa == `CS_CTRLA)
        ctrla_r <= cs_wd;
      if (cs_we && cs_wa == `CS_RESET_REQ) begin
        reset_req_r <= cs_wd;
        if (cs_wd == `RESET_SIGNATURE)
          sys_reset <= 1'b1;
        else if (cs_wd == `RESET_RELEASE)
          sys_reset <= 1'b0;
      end
    end
  end

  // Keys, protected modes and the erase handshake
  always @(posedge clk) begin
    if (rst) begin
      erase_key_r <= 1'b0;
      prog_key_r <= 1'b0;
      urow_key_r <= 1'b0;
      lock_r <= 1'b1;
      erase_start <= 1'b0;
      bod_force <= 1'b0;
      bod_active <= `BOD_ACTIVE_OFF;
      bod_level <= 3'h0;
      nvm_prog_en <= 1'b0;
      urow_prog_en <= 1'b0;
    end else begin
      lock_r <= lock_in;
      bod_level <= bod_cfg_level;
      if (port_disable)
        erase_key_r <= 1'b0;
      if (prog_done) begin
        prog_key_r <= 1'b0;
        nvm_prog_en <= 1'b0;
      end
      if (urow_clr)
        urow_key_r <= 1'b0;
      if (urow_done)
        urow_prog_en <= 1'b0;
      // Set after clear so a match in the clear cycle is kept
      if (key_done) begin
        if (key_next == `KEY_ERASE)
          erase_key_r <= 1'b1;
        if (key_next == `KEY_PROG)
          prog_key_r <= 1'b1;
        if (key_next == `KEY_UROW)
          urow_key_r <= 1'b1;
      end
      if (rst_release) begin
        if (erase_key_r) begin
          erase_start <= 1'b1;
          bod_force <= 1'b1;
          bod_active <= `BOD_ACTIVE_ON;
        end
        if (prog_key_r && !lock_r)
          nvm_prog_en <= 1'b1;
        if (urow_key_r && lock_r)
          urow_prog_en <= 1'b1;
      end
      if (erase_start && erase_done) begin
        erase_start <= 1'b0;
        bod_force <= 1'b0;
        bod_active <= `BOD_ACTIVE_OFF;
      end
      if (!prog_key_r)
        nvm_prog_en <= 1'b0;
    end
  end

  // Instruction sequencer
  always @(posedge clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      op_r <= 8'h00;
      rpt_r <= 8'h00;
      cnt_r <= 5'h00;
      idx_r <= 5'h00;
      addr_r <= 16'h0000;
      ptr_r <= 16'h0000;
      data_r <= 16'h0000;
      key_sr_r <= 64'h0;
      src_r <= SRC_DATA;
      byte_r <= 8'h00;
      first_r <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_idle <= 8'h00;
      bus_req <= 1'b0;
      bus_we <= 1'b0;
      bus_addr <= 16'h0000;
      bus_wdata <= 8'h00;
    end else if (rx_break) begin
      // Abandons any bus cycle; the slave must tolerate a dropped request
      state_r <= S_IDLE;
      rpt_r <= 8'h00;
      tx_valid <= 1'b0;
      bus_req <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (rx_synch)
            state_r <= S_INSTR;
        end
        S_INSTR: begin
          if (rx_valid) begin
            op_r <= rx_data;
            state_r <= S_START;
          end
        end
        S_START: begin
          idx_r <= 5'h00;
          first_r <= 1'b1;
          addr_r <= 16'h0000;
          data_r <= 16'h0000;
          case (op_class)
            `OP_DIRECT_LOAD, `OP_DIRECT_STORE: begin
              cnt_r <= abytes;
              state_r <= S_ADDR;
            end
            `OP_INDIRECT_LOAD: begin
              addr_r <= ptr_r;
              cnt_r <= dbytes;
              state_r <= S_BUS;
            end
            `OP_INDIRECT_STORE: begin
              addr_r <= ptr_r;
              cnt_r <= (ptr_mode == `PTR_WRITE) ? abytes : dbytes;
              state_r <= (ptr_mode == `PTR_WRITE) ? S_ADDR : S_DATA;
            end
            `OP_CS_LOAD: begin
              byte_r <= cs_read(op_r[3:0]);
              src_r <= SRC_BYTE;
              cnt_r <= 5'h01;
              state_r <= S_TX;
            end
            `OP_CS_STORE: state_r <= S_CSDATA;
            `OP_REPEAT: state_r <= S_RPT;
            `OP_KEY: begin
              if (op_r[`OPF_SIB]) begin
                src_r <= SRC_INFO;
                cnt_r <= op_r[`OPF_KSIZE] ? `SIB_LONG_BYTES :
                  `SIB_SHORT_BYTES;
                state_r <= S_TX;
              end else begin
                cnt_r <= `KEY_BYTES;
                state_r <= S_KEY;
              end
            end
            default: state_r <= S_IDLE;
          endcase
        end
        S_ADDR: begin
          if (rx_valid) begin
            if (idx_r == 5'h00)
              addr_r <= {8'h00, rx_data};
            else
              addr_r <= {rx_data, addr_r[7:0]};
            idx_r <= idx_r + 5'h01;
            if (last_idx) begin
              idx_r <= 5'h00;
              cnt_r <= dbytes;
              if (op_class == `OP_INDIRECT_STORE) begin
                ptr_r <= (idx_r == 5'h00) ? {8'h00, rx_data} :
                  {rx_data, addr_r[7:0]};
                byte_r <= `ACK_BYTE;
                src_r <= SRC_BYTE;
                cnt_r <= 5'h01;
                state_r <= S_TX;
              end else if (op_class == `OP_DIRECT_STORE) begin
                state_r <= S_DATA;
              end else begin
                state_r <= S_BUS;
              end
            end
          end
        end
        S_DATA: begin
          if (rx_valid) begin
            if (idx_r == 5'h00)
              data_r <= {8'h00, rx_data};
            else
              data_r <= {rx_data, data_r[7:0]};
            idx_r <= last_idx ? 5'h00 : idx_r + 5'h01;
            if (last_idx)
              state_r <= S_BUS;
          end
        end
        S_BUS: begin
          if (lock_r) begin
            // Locked: no bus cycle, loads return zero, stores stay silent
            idx_r <= 5'h00;
            data_r <= 16'h0000;
            src_r <= SRC_DATA;
            if (op_class == `OP_DIRECT_LOAD ||
                op_class == `OP_INDIRECT_LOAD) begin
              state_r <= S_TX;
            end else begin
              // Loads count down in S_TX
              state_r <= (rpt_r != 8'h00) ? S_START : S_IDLE;
              if (rpt_r != 8'h00)
                rpt_r <= rpt_r - 8'h01;
            end
          end else if (bus_req) begin
            if (bus_ack) begin
              bus_req <= 1'b0;
              if (!bus_we) begin
                if (idx_r == 5'h00)
                  data_r[7:0] <= bus_rdata;
                else
                  data_r[15:8] <= bus_rdata;
              end
              idx_r <= idx_r + 5'h01;
            end
          end else if (idx_r == cnt_r) begin
            idx_r <= 5'h00;
            if (op_class[2:0] == `OP_INDIRECT_LOAD ||
                op_class[2:0] == `OP_INDIRECT_STORE) begin
              if (ptr_mode == `PTR_POSTINC)
                ptr_r <= ptr_r + {11'h000, cnt_r};
            end
            if (op_class == `OP_DIRECT_LOAD ||
                op_class == `OP_INDIRECT_LOAD) begin
              src_r <= SRC_DATA;
            end else begin
              byte_r <= `ACK_BYTE;
              src_r <= SRC_BYTE;
              cnt_r <= 5'h01;
            end
            state_r <= S_TX;
          end else begin
            bus_req <= 1'b1;
            bus_we <= (op_class == `OP_DIRECT_STORE) ||
              (op_class == `OP_INDIRECT_STORE);
            bus_addr <= addr_r + {11'h000, idx_r};
            bus_wdata <= (idx_r == 5'h00) ? data_r[7:0] : data_r[15:8];
          end
        end
        S_TX: begin
          if (!tx_valid) begin
            tx_valid <= 1'b1;
            case (src_r)
              SRC_INFO: tx_data <= INFO_BLOCK[{idx_r[3:0], 3'h0} +: 8];
              SRC_BYTE: tx_data <= byte_r;
              default: tx_data <= idx_r[0] ? data_r[15:8] : data_r[7:0];
            endcase
            if (first_r)
              tx_idle <= guard_bits(ctrla_r[2:0]);
            else if (ctrla_r[`CTRLA_INTERBYTE_DELAY_ENABLE])
              tx_idle <= `IB_IDLE_BITS + `IB_EXTRA_BITS;
            else
              tx_idle <= `IB_IDLE_BITS;
          end else if (tx_ready) begin
            tx_valid <= 1'b0;
            first_r <= 1'b0;
            idx_r <= idx_r + 5'h01;
            if (last_idx) begin
              if (rpt_r != 8'h00) begin
                rpt_r <= rpt_r - 8'h01;
                state_r <= S_START;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
        end
        S_KEY: begin
          if (rx_valid) begin
            key_sr_r <= key_next;
            idx_r <= idx_r + 5'h01;
            if (last_idx) begin
              if (rpt_r != 8'h00) begin
                rpt_r <= rpt_r - 8'h01;
                state_r <= S_START;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
        end
        S_CSDATA: begin
          if (rx_valid) begin
            if (rpt_r != 8'h00) begin
              rpt_r <= rpt_r - 8'h01;
              state_r <= S_START;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_RPT: begin
          if (rx_valid) begin
            rpt_r <= rx_data;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // dbg_port_cmd

// ### dbg_port_consts.vh
// Constants for the debug port command layer.
// Assumes inclusion by bare name from the command layer module.
`ifndef DBG_PORT_CONSTS_VH
`define DBG_PORT_CONSTS_VH

// Opcode classes, top three bits of the instruction byte
`define OP_DIRECT_LOAD 3'h0
`define OP_INDIRECT_LOAD 3'h1
`define OP_DIRECT_STORE 3'h2
`define OP_INDIRECT_STORE 3'h3
`define OP_CS_LOAD 3'h4
`define OP_REPEAT 3'h5
`define OP_CS_STORE 3'h6
`define OP_KEY 3'h7

// Opcode fields
`define OPF_CLASS_HI 7
`define OPF_CLASS_LO 5
`define OPF_ASIZE 2
`define OPF_DSIZE 0
`define OPF_PTR_HI 3
`define OPF_PTR_LO 2
`define OPF_SIB 2
`define OPF_KSIZE 0
`define PTR_PLAIN 2'h0
`define PTR_POSTINC 2'h1
`define PTR_WRITE 2'h2

// Control and status space offsets
`define CS_CTRLA 4'h2
`define CS_KEY_STATUS 4'h7
`define CS_RESET_REQ 4'h8
`define CS_SYS_STATUS 4'hb

// Control register fields and reset value
`define CTRLA_INTERBYTE_DELAY_ENABLE 7
`define CTRLA_RESET 8'h00

// Key status bit positions
`define KS_ERASE 3
`define KS_PROG 4
`define KS_UROW 5

// System status bit positions
`define SS_LOCK 0
`define SS_USER_ROW_PROGRAMMING_FLAG 2
`define SS_MEMORY_PROGRAMMING_KEY 3
`define SS_RSTSYS 5

// Reset request values
`define RESET_SIGNATURE 8'h59
`define RESET_RELEASE 8'h00
`define RESET_REQ_RESET 8'h00

// Key signatures, least significant byte received first
`define KEY_ERASE 64'h4e564d4572617365
`define KEY_PROG 64'h4e564d50726f6720
`define KEY_UROW 64'h4e564d5573267465

// Link framing, plus brown-out activity codes
`define ACK_BYTE 8'h40
`define KEY_BYTES 5'h08
`define SIB_SHORT_BYTES 5'h08
`define SIB_LONG_BYTES 5'h10
`define IB_IDLE_BITS 8'h02
`define IB_EXTRA_BITS 8'h02
`define GT_MAX_BITS 8'h80
`define GT_NONE 3'h7
`define BOD_ACTIVE_ON 2'h1
`define BOD_ACTIVE_OFF 2'h0

`endif

// ### dbg_port_cmd_props.sv
// Checker for the debug port command layer, on its top ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module dbg_port_cmd_props (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Link
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_synch,
  input wire rx_break,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire [7:0] tx_idle,
  input wire tx_ready,
  // Bus
  input wire bus_req,
  input wire [15:0] bus_addr,
  input wire bus_ack,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  // System control
  input wire lock_in,
  input wire [2:0] bod_cfg_level,
  input wire sys_reset,
  input wire erase_start,
  input wire bod_force,
  input wire [1:0] bod_active,
  input wire [2:0] bod_level,
  input wire urow_prog_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the control register; link writes to it are not tracked
  reg [7:0] ctrl_r;
  reg want_op_r;
  reg cs_data_r;
  wire [7:0] guard = (ctrl_r[2:0] == 3'h7) ? 8'h00 : 8'h80 >> ctrl_r[2:0];
  always @(posedge clk) begin
    if (rst) begin
      ctrl_r <= 8'h00;
      want_op_r <= 1'b0;
      cs_data_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 4'h2)
        ctrl_r <= reg_wdata;
      if (rx_synch || rx_break)
        want_op_r <= rx_synch;
      else if (rx_valid)
        want_op_r <= 1'b0;
      if (rx_valid)
        cs_data_r <= want_op_r && rx_data[7:5] == 3'h6;
    end
  end
  property p_cs_quiet;
    cs_data_r && rx_valid |=> !tx_valid [*6];
  endproperty
  a_cs_quiet: assert property (p_cs_quiet)
    else $error("reply after control store");
  property p_idle;
    tx_valid |-> tx_idle == guard || tx_idle == (ctrl_r[7] ? 8'h04 : 8'h02);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle bit count wrong");
  property p_tx_hold;
    tx_valid && !tx_ready && !rx_break |=>
      tx_valid && $stable(tx_data) && $stable(tx_idle);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte not held");
  property p_rst_set;
    reg_wr && reg_addr == 4'h8 && reg_wdata == 8'h59 |-> ##[1:2] sys_reset;
  endproperty
  a_rst_set: assert property (p_rst_set)
    else $error("signature did not reset system");
  property p_rst_clr;
    reg_wr && reg_addr == 4'h8 && reg_wdata == 8'h00 |-> ##[1:2] !sys_reset;
  endproperty
  a_rst_clr: assert property (p_rst_clr)
    else $error("zero did not release reset");
  property p_bod;
    $past(erase_start) && erase_start |-> bod_force && bod_active == 2'h1;
  endproperty
  a_bod: assert property (p_bod)
    else $error("brown-out not forced in erase");
  property p_bod_lvl;
    !$past(rst) |-> bod_level == $past(bod_cfg_level);
  endproperty
  a_bod_lvl: assert property (p_bod_lvl)
    else $error("brown-out level not from fuse");
  property p_locked;
    $rose(bus_req) |-> !$past(lock_in);
  endproperty
  a_locked: assert property (p_locked)
    else $error("bus access while locked");
  property p_bus_hold;
    bus_req && !bus_ack && !rx_break |=> bus_req && $stable(bus_addr);
  endproperty
  a_bus_hold: assert property (p_bus_hold)
    else $error("bus request not held");
  property p_urow;
    $rose(urow_prog_en) |-> $past(lock_in);
  endproperty
  a_urow: assert property (p_urow)
    else $error("user row enabled while unlocked");
endmodule // dbg_port_cmd_props

// ### dbg_host_model.sv
// Far side: link byte sink for the debugger and PHY, plus system memory.
// Assumes the command layer's clock; slow stretches every answer.
`timescale 1ns/10ps
module dbg_host_model (
  // Clock, reset and pace
  input wire clk,
  input wire rst,
  input wire slow,
  // Link transmit side
  input wire tx_valid,
  output reg tx_ready,
  // System bus
  input wire bus_req,
  input wire bus_we,
  input wire [15:0] bus_addr,
  input wire [7:0] bus_wdata,
  output reg bus_ack,
  output reg [7:0] bus_rdata
);
  reg [7:0] mem [0:255];
  reg [2:0] tx_wait_r;
  reg [2:0] bus_wait_r;
  integer i;
  initial begin
    bus_rdata = 8'h00;
    for (i = 0; i < 256; i = i + 1)
      mem[i] = i[7:0] ^ 8'h5a;
  end
  always @(posedge clk) begin
    tx_ready <= 1'b0;
    bus_ack <= 1'b0;
    // Idle read data keeps moving so a stale byte never looks valid
    bus_rdata <= bus_rdata + 8'h01;
    if (rst) begin
      tx_wait_r <= 3'h0;
      bus_wait_r <= 3'h0;
    end else begin
      if (tx_valid && !tx_ready) begin
        tx_wait_r <= tx_wait_r + 3'h1;
        if (tx_wait_r >= (slow ? 3'h5 : 3'h1)) begin
          tx_ready <= 1'b1;
          tx_wait_r <= 3'h0;
        end
      end
      if (bus_req && !bus_ack) begin
        bus_wait_r <= bus_wait_r + 3'h1;
        if (bus_wait_r >= (slow ? 3'h4 : 3'h0)) begin
          bus_ack <= 1'b1;
          bus_wait_r <= 3'h0;
          if (bus_we)
            mem[bus_addr[7:0]] <= bus_wdata;
          else
            bus_rdata <= mem[bus_addr[7:0]];
        end
      end
    end
  end
endmodule // dbg_host_model

// ### tb_top.sv
// Self-checking bench for the debug port command layer.
// Assumes the host model on the far side and the checker bound below.
`timescale 1ns/10ps
`include "dbg_port_consts.vh"
module tb_top;
  localparam [127:0] INFO = 128'h0f00333231363534_0041424344454647;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg rx_valid = 1'b0, rx_synch = 1'b0, rx_break = 1'b0, slow = 1'b0;
  reg reg_wr = 1'b0, reg_rd = 1'b0, lock_in = 1'b1;
  reg urow_done = 1'b0, port_disable = 1'b0, prog_done = 1'b0;
  reg erase_done = 1'b0;
  reg [7:0] rx_data = 8'h00, reg_wdata = 8'h00;
  reg [3:0] reg_addr = 4'h0;
  reg [2:0] bod_cfg_level = 3'h5;
  wire tx_valid, tx_ready, bus_req, bus_we, bus_ack, sys_reset, erase_start;
  wire bod_force, nvm_prog_en, urow_prog_en;
  wire [7:0] tx_data, tx_idle, bus_wdata, bus_rdata, reg_rdata;
  wire [15:0] bus_addr;
  wire [1:0] bod_active;
  wire [2:0] bod_level;
  integer n_errors = 0, n_tests = 0, i;
  reg [7:0] txd [$];
  reg [7:0] txi [$];
  reg [15:0] bwa [$];
  reg [7:0] bwd [$];
  always #5 clk = ~clk;
  dbg_port_cmd #(.INFO_BLOCK(INFO)) u_dbg_port_cmd (
    .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_synch(rx_synch), .rx_break(rx_break), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_idle(tx_idle), .tx_ready(tx_ready),
    .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock_in(lock_in),
    .prog_done(prog_done), .urow_done(urow_done),
    .port_disable(port_disable), .erase_done(erase_done),
    .bod_cfg_level(bod_cfg_level), .sys_reset(sys_reset),
    .erase_start(erase_start), .bod_force(bod_force),
    .bod_active(bod_active), .bod_level(bod_level),
    .nvm_prog_en(nvm_prog_en), .urow_prog_en(urow_prog_en));
  dbg_host_model u_dbg_host_model (
    .clk(clk), .rst(rst), .slow(slow), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata));
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      txd.push_back(tx_data);
      txi.push_back(tx_idle);
    end
    if (bus_req && bus_ack && bus_we) begin
      bwa.push_back(bus_addr);
      bwd.push_back(bus_wdata);
    end
  end
  task chk(input [7:0] g, e, input [79:0] w);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: %0s got %h want %h", $time, w, g, e);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task tdone(input [79:0] s);
    begin
      $display("test %0s done", s);
      txd.delete();
      txi.delete();
      bwa.delete();
      bwd.delete();
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e, "reg read");
    end
  endtask
  // Waits for link and bus to fall silent; a hang counts as a mismatch
  task quiet;
    integer q, k;
    begin
      q = 0;
      for (k = 0; k < 400 && q < 8; k = k + 1) begin
        @(posedge clk);
        q = (tx_valid || bus_req) ? 0 : q + 1;
      end
      chk({7'h0, q < 8}, 8'h00, "hang");
    end
  endtask
  task snd(input [7:0] b);
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= b;
      @(posedge clk);
      rx_valid <= 1'b0;
      quiet;
    end
  endtask
  task cmd(input [7:0] op);
    begin
      @(posedge clk);
      rx_synch <= 1'b1;
      @(posedge clk);
      rx_synch <= 1'b0;
      snd(op);
    end
  endtask
  task key(input [63:0] k);
    begin
      cmd(8'he0);
      for (i = 0; i < 8; i = i + 1)
        snd(k[8*i +: 8]);
    end
  endtask
  task pulse(input [1:0] w);
    begin
      @(posedge clk);
      {urow_done, port_disable, prog_done, erase_done} <= 4'h1 << w;
      @(posedge clk);
      {urow_done, port_disable, prog_done, erase_done} <= 4'h0;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors = n_errors + 1;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(4'hb, 8'h01);
    rd(4'h7, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h4, 8'h00);
    tdone("reset");
    key(`KEY_PROG);
    rd(4'h7, 8'h10);
    key(`KEY_ERASE);
    rd(4'h7, 8'h18);
    key(`KEY_ERASE ^ 64'h1);
    rd(4'h7, 8'h18);
    chk(8'(txd.size()), 8'h00, "key reply");
    tdone("keys");
    cmd(8'h00);
    snd(8'h40);
    chk(8'(bwa.size()), 8'h00, "locked");
    chk(txd[0], 8'h00, "locked");
    bod_cfg_level <= 3'h2;
    wr(4'h8, 8'h59);
    rd(4'hb, 8'h21);
    wr(4'h8, 8'h00);
    rd(4'hb, 8'h01);
    chk({7'h0, erase_start}, 8'h01, "erase");
    chk({2'h0, bod_force, bod_active, bod_level}, 8'h2a, "bod");
    @(posedge clk);
    lock_in <= 1'b0;
    pulse(0);
    rd(4'hb, 8'h00);
    chk({6'h0, erase_start, bod_force}, 8'h00, "erase end");
    pulse(2);
    rd(4'h7, 8'h10);
    wr(4'h8, 8'h59);
    wr(4'h8, 8'h00);
    rd(4'hb, 8'h08);
    chk({7'h0, nvm_prog_en}, 8'h01, "prog en");
    pulse(1);
    rd(4'h7, 8'h00);
    tdone("erase");
    cmd(8'h68);
    snd(8'h40);
    cmd(8'ha0);
    snd(8'h02);
    cmd(8'h64);
    for (i = 1; i < 5; i = i + 1)
      snd(8'h11 * i[7:0]);
    chk(8'(bwa.size()), 8'h03, "repeat");
    for (i = 0; i < 3; i = i + 1) begin
      chk(bwa[i][7:0], 8'h40 + i[7:0], "addr");
      chk(bwd[i], 8'h11 * (i[7:0] + 8'h01), "data");
    end
    chk(8'(txd.size()), 8'h04, "acks");
    tdone("repeat");
    for (i = 0; i < 2; i = i + 1) begin
      wr(4'h2, i ? 8'h04 : 8'h84);
      cmd(8'h25);
      chk(txi[2*i], 8'h08, "guard");
      chk(txi[2*i+1], i ? 8'h02 : 8'h04, "gap");
    end
    chk(txd[1], 8'h1e, "load");
    chk(txd[3], 8'h1c, "load");
    tdone("delay");
    cmd(8'he5);
    cmd(8'he4);
    chk(8'(txd.size()), 8'd24, "info len");
    for (i = 0; i < 24; i = i + 1)
      chk(txd[i], INFO[8*(i % 16) +: 8], "info");
    chk(txi[1], 8'h02, "info gap");
    tdone("info");
    cmd(8'hc8);
    snd(8'h59);
    chk({7'h0, sys_reset}, 8'h01, "cs store");
    cmd(8'hc8);
    snd(8'h00);
    chk({7'h0, sys_reset}, 8'h00, "cs store");
    chk(8'(txd.size()), 8'h00, "cs reply");
    tdone("control");
    @(posedge clk);
    slow <= 1'b1;
    cmd(8'ha0);
    snd(8'h05);
    cmd(8'h40);
    snd(8'h50);
    snd(8'haa);
    snd(8'h51);
    snd(8'hbb);
    @(posedge clk);
    rx_break <= 1'b1;
    @(posedge clk);
    rx_break <= 1'b0;
    snd(8'h52);
    snd(8'hcc);
    chk(8'(bwa.size()), 8'h02, "break");
    chk(bwa[1][7:0], 8'h51, "direct");
    chk(bwd[1], 8'hbb, "direct");
    tdone("break");
    @(posedge clk);
    lock_in <= 1'b1;
    key(`KEY_UROW);
    wr(4'h8, 8'h59);
    wr(4'h8, 8'h00);
    rd(4'hb, 8'h05);
    wr(4'h7, 8'h20);
    rd(4'h7, 8'h00);
    pulse(3);
    #1 chk({7'h0, urow_prog_en}, 8'h00, "urow done");
    key(`KEY_PROG);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h7, 8'h00);
    tdone("user row");
    print_verdict;
  end
endmodule // tb_top
bind dbg_port_cmd dbg_port_cmd_props u_dbg_port_cmd_props (
  .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_synch(rx_synch), .rx_break(rx_break), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_idle(tx_idle), .tx_ready(tx_ready),
  .bus_req(bus_req), .bus_addr(bus_addr), .bus_ack(bus_ack),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .lock_in(lock_in), .bod_cfg_level(bod_cfg_level), .sys_reset(sys_reset),
  .erase_start(erase_start), .bod_force(bod_force),
  .bod_active(bod_active), .bod_level(bod_level),
  .urow_prog_en(urow_prog_en));
